/* verilog/lcd_ctl_defs.svh */
`ifndef LCD_CTL_DEFS_SVH
`define LCD_CTL_DEFS_SVH
// register offsets on the plain register port
`define ADDR_XFER     4'h0
`define ADDR_START    4'h1
`define ADDR_CFG      4'h2
`define ADDR_PTR      4'h3
// command byte fields
`define CMD_CONT      7
`define CMD_CLASS     6
`define CMD_SUB5      5
`define CMD_SUB4      4
`define CMD_BANK_SEL  6:2
`define CMD_BANK_CODE 5'h1F
`define CMD_TYPE      4
`define CMD_STAT      3:2
`define CMD_MUX       1:0
`define CMD_XADDR     5:0
`define CMD_SUBADDR   3:0
`define CMD_ORDER     3:2
`define CMD_YBANK     1:0
// display memory geometry
`define X_LAST        6'h27
`define BANK_LAST     2'h3
`define OWN_SUBADDR   4'h0
// timing: oscillator and system clock in Hz
`define SYS_FREQ_HZ   25000000
`define OSC_FREQ_HZ   12288
`define DIV_STD       4'h6
`define DIV_24        4'h8
`define FRAME_STD     6'h20
`define FRAME_24      6'h18
// row index shifts per multiplex rate
`define SHIFT_8       2'h2
`define SHIFT_16      2'h1
`define SHIFT_NONE    2'h0
// masks folding outputs onto rows in row mode
`define MASK_8        5'h07
`define MASK_16       5'h0F
`define MASK_ALL      5'h1F
`define ROW_OUTS      6'h20
`define ROWS_8        6'h08
`define ROWS_16       6'h10
`define ROWS_24       6'h18
`endif

/* verilog/lcd_ctl_pkg.sv */
package lcd_ctl_pkg;
  // multiplex rate, coded as carried by the mode command
  typedef enum logic [1:0] {
    MUX_32 = 2'b00,
    MUX_8  = 2'b01,
    MUX_16 = 2'b10,
    MUX_24 = 2'b11
  } mux_t;
  // display presentation
  typedef enum logic [1:0] {
    ST_BLANK   = 2'b00,
    ST_NORMAL  = 2'b01,
    ST_ALL_ON  = 2'b10,
    ST_INVERSE = 2'b11
  } status_t;
  // memory access order
  typedef enum logic [1:0] {
    ORD_CHAR = 2'b00,
    ORD_HALF = 2'b01,
    ORD_FULL = 2'b10,
    ORD_RSVD = 2'b11
  } order_t;
  // display configuration set by commands
  typedef struct packed {
    logic    mixed;
    status_t status;
    mux_t    mux;
    logic [1:0] top_bank;
  } disp_cfg_t;
  // data pointer with subaddress counter
  typedef struct packed {
    logic [3:0] sub;
    logic [5:0] x;
    logic [1:0] bank;
    order_t     order;
  } ptr_t;
  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;
endpackage : lcd_ctl_pkg

/* verilog/lcd_matrix_row_column_controller.sv */
`timescale 1ns/1ps
`include "lcd_ctl_defs.svh"
// Contract
// - reset: blank, 1:32 row mode, pointers zero
// - cascade clock is oscillator over 6, or 8
// - frame sync period is whole clock periods
// - 64 Hz frame: 2048 or 1536 Hz clock
// - 8 rows, 8 columns, 24 shared by eights
// - rows pulse in order; spare shared outputs columns
// - row count follows multiplex rate
// - row mode: shared are rows, fixed columns idle
// - 1:16 doubles, 1:8 quadruples row pulses
// - memory is four banks of forty bytes
// - columns 0-7 stored, not shown; X equals output
// - data only when subaddress counter is zero
// - reads only in mixed mode
// - memory access only in mixed mode
// - three access orders from two-bit field
// - subaddress advances, wraps 15 to 0
// - mode command sets rows and presentation
// - start bank picks top displayed bank
// - command top bit means another command follows
// - pointer advances per data byte; subaddress when X wraps; code steps it in mixed mode only
module lcd_matrix_row_column_controller #(
  parameter int OSC_DIV_CYC = `SYS_FREQ_HZ / `OSC_FREQ_HZ  // system cycles per oscillator tick
) (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  resetn,
  // register port
  input  wire lcd_ctl_pkg::bus_req_t bus_req,
  output logic [7:0]                 rdata,
  // clock source pins
  input  wire logic                  osc_resistor_input,
  input  wire logic                  cascade_clk_in,
  output logic                       cascade_clk_out,
  output logic                       cascade_clk_oe,
  // cascade frame sync, active low
  output logic                       frame_sync_n,
  // driver outputs: row function mask and active level
  output logic [39:0]                drv_is_row,
  output logic [39:0]                drv_on,
  // configuration and pointer view
  output lcd_ctl_pkg::disp_cfg_t     cfg,
  output lcd_ctl_pkg::ptr_t          ptr
);
  import lcd_ctl_pkg::*;

  // refuse a prescaler that cannot count
  if (OSC_DIV_CYC < 1 || OSC_DIV_CYC > 65535) begin : g_chk
    $error("OSC_DIV_CYC out of range");
  end

  disp_cfg_t  cfg_q;                  // display configuration
  ptr_t       ptr_q;                  // data pointer
  logic       cmd_phase_q;            // next byte is a command
  logic [7:0] mem_q [4][40];          // display memory, bank by column
  logic [7:0] rdata_q;                // read answer
  logic       ext_s1_q;               // external clock sync stage 1
  logic       ext_s2_q;               // external clock sync stage 2
  logic       ext_s3_q;               // edge history
  logic       osc_s1_q;               // oscillator strap sync stage 1
  logic       ext_mode_q;             // strap synchronised: external clock
  logic [15:0] osc_cnt_q;             // prescaler
  logic [3:0] div_cnt_q;              // cascade divider
  logic [5:0] frame_cnt_q;            // cascade clocks within a frame
  logic       casc_out_q;             // cascade clock level
  logic       casc_oe_q;              // cascade clock driven
  logic       sync_n_q;               // frame sync level
  logic [39:0] is_row_q;              // registered row mask
  logic [39:0] on_q;                  // registered drive levels

  // decoded strobes
  logic wr_xfer;
  logic cmd_wr;
  logic dat_wr;
  logic dat_rd;
  logic ram_hit;
  logic [7:0] wd;
  assign wd      = bus_req.wdata;
  assign wr_xfer = bus_req.wr && bus_req.addr == `ADDR_XFER;
  assign cmd_wr  = wr_xfer && cmd_phase_q;
  assign dat_wr  = wr_xfer && !cmd_phase_q;
  assign dat_rd  = bus_req.rd && bus_req.addr == `ADDR_XFER;
  // only our own subaddress, only in mixed mode, touches memory
  assign ram_hit = cfg_q.mixed && ptr_q.sub == `OWN_SUBADDR;

  // command kinds
  logic is_xload;
  logic is_mode;
  logic is_devsel;
  logic is_bank;
  logic is_access;
  assign is_xload  = cmd_wr && !wd[`CMD_CLASS];
  assign is_mode   = cmd_wr && wd[`CMD_CLASS] && !wd[`CMD_SUB5];
  assign is_devsel = cmd_wr && wd[`CMD_CLASS] && wd[`CMD_SUB5] && !wd[`CMD_SUB4];
  // codes twelve and up under the access prefix mean start bank
  assign is_bank   = cmd_wr && wd[`CMD_BANK_SEL] == `CMD_BANK_CODE;
  assign is_access = cmd_wr && wd[`CMD_CLASS] && wd[`CMD_SUB5] && wd[`CMD_SUB4]
                     && !is_bank;

  // command phase: opened by a start, closed by a clear top bit
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmd_phase_q <= 1'b1;
    end else if (bus_req.wr && bus_req.addr == `ADDR_START) begin
      cmd_phase_q <= 1'b1;
    end else if (cmd_wr && !wd[`CMD_CONT]) begin
      cmd_phase_q <= 1'b0;
    end
  end

  // display configuration from mode and start bank commands
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= '{mixed: 1'b0, status: ST_BLANK, mux: MUX_32, top_bank: 2'h0};
    end else if (is_mode) begin
      cfg_q.mixed  <= wd[`CMD_TYPE];
      cfg_q.status <= status_t'(wd[`CMD_STAT]);
      cfg_q.mux    <= mux_t'(wd[`CMD_MUX]);
    end else if (is_bank) begin
      cfg_q.top_bank <= wd[`CMD_YBANK];
    end
  end

  // pointer step per data byte; x past the last column
  // moves to the next device, the counter wraps by itself
  function automatic ptr_t step(input ptr_t p);
    ptr_t n;
    logic x_adv;
    n     = p;
    x_adv = 1'b0;
    unique case (p.order)
      ORD_HALF: begin
        if (p.bank[0]) begin
          n.bank[0] = 1'b0;
          x_adv     = 1'b1;
        end else begin
          n.bank[0] = 1'b1;
        end
      end
      ORD_FULL: begin
        if (p.bank == `BANK_LAST) begin
          n.bank = 2'h0;
          x_adv  = 1'b1;
        end else begin
          n.bank = p.bank + 2'h1;
        end
      end
      ORD_CHAR, ORD_RSVD: x_adv = 1'b1;                      // reserved runs as character
    endcase
    if (x_adv) begin
      if (p.x == `X_LAST) begin
        n.x   = 6'h00;
        n.sub = p.sub + 4'h1;
      end else begin
        n.x = p.x + 6'h01;
      end
    end
    return n;
  endfunction : step

  // data pointer: loaded by commands, stepped by data bytes in mixed mode
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ptr_q <= '{sub: 4'h0, x: 6'h00, bank: 2'h0, order: ORD_CHAR};
    end else if (is_xload) begin
      ptr_q.x <= wd[`CMD_XADDR];
    end else if (is_devsel) begin
      ptr_q.sub <= wd[`CMD_SUBADDR];
    end else if (is_access) begin
      ptr_q.order <= order_t'(wd[`CMD_ORDER]);
      ptr_q.bank  <= wd[`CMD_YBANK];
    end else if ((dat_wr || dat_rd) && cfg_q.mixed) begin
      ptr_q <= step(ptr_q);
    end
  end

  // display memory write; an x beyond the last column is not stored
  always_ff @(posedge clock) begin
    if (dat_wr && ram_hit && ptr_q.x <= `X_LAST) begin
      mem_q[ptr_q.bank][ptr_q.x] <= wd;
    end
  end

  // read answer, valid the cycle after the read strobe only
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (dat_rd) begin
      // row mode never transmits: the answer stays zero
      rdata_q <= (ram_hit && ptr_q.x <= `X_LAST) ? mem_q[ptr_q.bank][ptr_q.x] : 8'h00;
    end else if (bus_req.rd && bus_req.addr == `ADDR_CFG) begin
      rdata_q <= {1'b0, cfg_q};
    end else if (bus_req.rd && bus_req.addr == `ADDR_PTR) begin
      rdata_q <= {ptr_q.sub, ptr_q.bank, ptr_q.order};
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // clock source pins cross in through two flip-flops
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ext_s1_q   <= 1'b0;
      ext_s2_q   <= 1'b0;
      ext_s3_q   <= 1'b0;
      osc_s1_q   <= 1'b0;
      ext_mode_q <= 1'b0;
    end else begin
      ext_s1_q   <= cascade_clk_in;
      ext_s2_q   <= ext_s1_q;
      ext_s3_q   <= ext_s2_q;
      osc_s1_q   <= osc_resistor_input;
      ext_mode_q <= osc_s1_q;
    end
  end

  // oscillator stand-in: a prescaler of the system clock
  logic osc_tick;
  assign osc_tick = !ext_mode_q && osc_cnt_q == 16'(OSC_DIV_CYC - 1);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      osc_cnt_q <= 16'h0000;
    end else if (ext_mode_q || osc_tick) begin
      osc_cnt_q <= 16'h0000;
    end else begin
      osc_cnt_q <= osc_cnt_q + 16'h0001;
    end
  end

  // cascade divider: six, or eight at 1:24
  logic [3:0] div_len;
  logic [3:0] div_nxt;
  logic       casc_tick;
  assign div_len   = (cfg_q.mux == MUX_24) ? `DIV_24 : `DIV_STD;
  assign div_nxt   = (div_cnt_q >= div_len - 4'h1) ? 4'h0 : div_cnt_q + 4'h1;
  // an external clock steps the frame on its rising edge instead
  assign casc_tick = ext_mode_q ? (ext_s2_q && !ext_s3_q)
                                : (osc_tick && div_nxt == 4'h0);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_cnt_q  <= 4'h0;
      casc_out_q <= 1'b0;
    end else if (osc_tick) begin
      div_cnt_q  <= div_nxt;
      casc_out_q <= div_nxt < (div_len >> 1);                // high for the first half
    end
  end

  // cascade pin is driven only while the oscillator is in use
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      casc_oe_q <= 1'b0;
    end else begin
      casc_oe_q <= !ext_mode_q;
    end
  end

  // frame counter in cascade clocks; sync low for the first one
  logic [5:0] frame_len;
  logic [5:0] frame_nxt;
  assign frame_len = (cfg_q.mux == MUX_24) ? `FRAME_24 : `FRAME_STD;
  assign frame_nxt = (frame_cnt_q >= frame_len - 6'h01) ? 6'h00 : frame_cnt_q + 6'h01;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      frame_cnt_q <= 6'h00;
      sync_n_q    <= 1'b1;
    end else if (casc_tick) begin
      frame_cnt_q <= frame_nxt;
      sync_n_q    <= frame_nxt != 6'h00;
    end
  end

  // row index for the coming cascade clock
  logic [1:0] shift;
  logic [4:0] row;
  logic [4:0] fold;
  logic [5:0] rows;
  always_comb begin
    unique case (cfg_q.mux)
      MUX_8: begin
        shift = `SHIFT_8;
        fold  = `MASK_8;
        rows  = `ROWS_8;
      end
      MUX_16: begin
        shift = `SHIFT_16;
        fold  = `MASK_16;
        rows  = `ROWS_16;
      end
      MUX_24: begin
        shift = `SHIFT_NONE;
        fold  = `MASK_ALL;
        rows  = `ROWS_24;
      end
      MUX_32: begin
        shift = `SHIFT_NONE;
        fold  = `MASK_ALL;
        rows  = `ROW_OUTS;
      end
    endcase
  end
  assign row = 5'(frame_nxt >> shift);

  // bank shown for this row, offset by the start bank
  logic [1:0] row_bank;
  assign row_bank = cfg_q.top_bank + row[4:3];

  // per output: role and level for the coming row
  logic [39:0] is_row_d;
  logic [39:0] on_d;
  for (genvar i = 0; i < 40; i++) begin : g_out
    logic pix;
    logic sel;
    assign pix = mem_q[row_bank][i][row[2:0]];
    // row mode folds outputs so 1:16 and 1:8 repeat each pulse
    assign sel = cfg_q.mixed ? (5'(i) == row) : ((5'(i) & fold) == row);
    always_comb begin
      if (i < 8) begin
        is_row_d[i] = 1'b1;
      end else if (i >= 32) begin
        is_row_d[i] = 1'b0;
      end else begin
        // shared outputs switch by eights; spare ones are columns
        is_row_d[i] = !cfg_q.mixed || 6'(i) < rows;
      end
      if (is_row_d[i]) begin
        on_d[i] = sel;
      end else if (!cfg_q.mixed) begin
        on_d[i] = 1'b0;
      end else begin
        unique case (cfg_q.status)
          ST_BLANK:   on_d[i] = 1'b0;
          ST_NORMAL:  on_d[i] = pix;
          ST_ALL_ON:  on_d[i] = 1'b1;
          ST_INVERSE: on_d[i] = !pix;
        endcase
      end
    end
  end

  // driver outputs change once per cascade clock
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      is_row_q <= '0;
      on_q     <= '0;
    end else if (casc_tick) begin
      is_row_q <= is_row_d;
      on_q     <= on_d;
    end
  end

  assign rdata           = rdata_q;
  assign cascade_clk_out = casc_out_q;
  assign cascade_clk_oe  = casc_oe_q;
  assign frame_sync_n    = sync_n_q;
  assign drv_is_row      = is_row_q;
  assign drv_on          = on_q;
  assign cfg             = cfg_q;
  assign ptr             = ptr_q;
endmodule : lcd_matrix_row_column_controller

/* test/lcd_ext_clock_src.sv */
`timescale 1ns/1ps
// far-side cascade clock source; stands still while not enabled
module lcd_ext_clock_src #(
  parameter int HALF_NS = 400  // half period, any phase
) (
  // enable from the bench
  input  wire logic run,
  // clock towards the cascade pin
  output logic      ext_clk
);
  // runs while enabled; a stopped clock freezes the panel
  initial begin
    ext_clk = 1'b0;
    #7;
    forever begin
      #HALF_NS;
      ext_clk = run ? ~ext_clk : 1'b0;
    end
  end
endmodule : lcd_ext_clock_src

/* test/lcd_ctl_checker.sv */
`timescale 1ns/1ps
`include "lcd_ctl_defs.svh"
// port checks; timing scales with the oscillator divider
module lcd_ctl_checker #(
  parameter int OSC_DIV_CYC = 2  // system cycles per oscillator tick
) (
  // clock and reset
  input wire logic                   clock,
  input wire logic                   resetn,
  // register port
  input wire lcd_ctl_pkg::bus_req_t  bus_req,
  input wire logic [7:0]             rdata,
  // clock pins and sync
  input wire logic                   osc_resistor_input,
  input wire logic                   cascade_clk_in,
  input wire logic                   cascade_clk_out,
  input wire logic                   cascade_clk_oe,
  input wire logic                   frame_sync_n,
  // drivers and state
  input wire logic [39:0]            drv_is_row,
  input wire logic [39:0]            drv_on,
  input wire lcd_ctl_pkg::disp_cfg_t cfg,
  input wire lcd_ctl_pkg::ptr_t      ptr
);
  import lcd_ctl_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  localparam int TICK   = OSC_DIV_CYC * 6;    // cascade period, most rates
  localparam int TICK24 = OSC_DIV_CYC * 8;    // cascade period at 1:24
  localparam int FRAME  = OSC_DIV_CYC * 192;  // same frame length at every rate
  disp_cfg_t   cfg_q;     // settings one cycle ago
  logic        osc_q;     // strap one cycle ago
  logic [1:0]  settle_q;  // frame starts still to pass after a change
  logic [15:0] low_q;     // cycles sync has been low
  logic [15:0] per_q;     // cycles since the last frame start
  logic        calm;      // settings steady long enough to judge timing
  assign calm = (settle_q == 2'h0) && (cfg == cfg_q) && (osc_resistor_input == osc_q);
  // delayed copies to spot setting changes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= '0;
      osc_q <= 1'b0;
    end else begin
      cfg_q <= cfg;
      osc_q <= osc_resistor_input;
    end
  end
  // a change mutes timing checks for two frames
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      settle_q <= 2'h2;
    end else if (cfg != cfg_q || osc_resistor_input != osc_q) begin
      settle_q <= 2'h2;
    end else if ($fell(frame_sync_n) && settle_q != 2'h0) begin
      settle_q <= settle_q - 2'h1;
    end
  end
  // sync pulse width and frame length counters
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      low_q <= 16'h0;
      per_q <= 16'h0;
    end else begin
      low_q <= frame_sync_n ? 16'h0 : low_q + 16'h1;
      per_q <= $fell(frame_sync_n) ? 16'h1 : per_q + 16'h1;
    end
  end
  property p_reset_state;
    $rose(resetn) |-> cfg == disp_cfg_t'{1'b0, ST_BLANK, MUX_32, 2'h0} && ptr == '0;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("bad reset state");
  property p_row_read_zero;
    bus_req.rd && bus_req.addr == `ADDR_XFER && !cfg.mixed |=> rdata == 8'h00;
  endproperty
  a_row_read_zero: assert property (p_row_read_zero)
    else $error("row mode read data");
  property p_ptr_quiet;
    !bus_req.wr && !bus_req.rd |=> $stable(ptr);
  endproperty
  a_ptr_quiet: assert property (p_ptr_quiet)
    else $error("pointer moved idle");
  property p_cfg_quiet;
    !bus_req.wr |=> $stable(cfg);
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet)
    else $error("settings moved idle");
  property p_fixed_outputs;
    drv_is_row[39:32] == 8'h00 && (drv_is_row[7:0] == 8'hFF || drv_is_row == '0);
  endproperty
  a_fixed_outputs: assert property (p_fixed_outputs)
    else $error("fixed output role");
  property p_row_mode_cols_off;
    !cfg.mixed && calm |-> drv_on[39:32] == 8'h00;
  endproperty
  a_row_mode_cols_off: assert property (p_row_mode_cols_off)
    else $error("fixed column on in row mode");
  property p_sync_width;
    $rose(frame_sync_n) && calm && !osc_resistor_input
      |-> low_q == ((cfg.mux == MUX_24) ? TICK24 : TICK);
  endproperty
  a_sync_width: assert property (p_sync_width)
    else $error("sync width");
  property p_frame_period;
    $fell(frame_sync_n) && calm && !osc_resistor_input |-> per_q == FRAME;
  endproperty
  a_frame_period: assert property (p_frame_period)
    else $error("frame length");
  property p_row_pattern;
    !frame_sync_n && calm && !cfg.mixed && cfg.status != ST_BLANK
      |-> drv_on[31:0] == ((cfg.mux == MUX_8) ? 32'h01010101 :
          (cfg.mux == MUX_16) ? 32'h00010001 : 32'h00000001);
  endproperty
  a_row_pattern: assert property (p_row_pattern)
    else $error("row select at frame start");
  property p_clk_released;
    osc_resistor_input [*4] |=> !cascade_clk_oe;
  endproperty
  a_clk_released: assert property (p_clk_released)
    else $error("pin driven, external clock");
  property p_clk_driven;
    (!osc_resistor_input) [*4] |=> cascade_clk_oe;
  endproperty
  a_clk_driven: assert property (p_clk_driven)
    else $error("pin idle, internal clock");
endmodule : lcd_ctl_checker

bind lcd_matrix_row_column_controller lcd_ctl_checker #(.OSC_DIV_CYC(OSC_DIV_CYC))
  lcd_ctl_checker_inst (.clock(clock), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
  .osc_resistor_input(osc_resistor_input), .cascade_clk_in(cascade_clk_in),
  .cascade_clk_out(cascade_clk_out), .cascade_clk_oe(cascade_clk_oe),
  .frame_sync_n(frame_sync_n), .drv_is_row(drv_is_row), .drv_on(drv_on), .cfg(cfg),
  .ptr(ptr));

/* test/lcd_matrix_row_column_controller_test.sv */
`timescale 1ns/1ps
`include "lcd_ctl_defs.svh"
// register tests with a far-side clock source
module lcd_matrix_row_column_controller_test;
  import lcd_ctl_pkg::*;
  localparam int DIV = 2;   // short oscillator divider keeps frames brief
  localparam int EXT = 20;  // external clock period in system cycles
  logic        clock;       // system clock
  logic        resetn;      // active low reset
  bus_req_t    bus_req;     // register request
  logic [7:0]  rdata;       // register read data
  logic        strap;       // external clock select
  logic        ext_clk;     // partner clock
  logic        clk_pin;     // resolved cascade pin
  logic        clk_out;     // our level onto the pin
  logic        clk_oe;      // our drive enable
  logic        sync_n;      // frame sync
  logic [39:0] is_row;      // row function mask
  logic [39:0] drv_on;      // driver activity
  disp_cfg_t   cfg;         // settings view
  ptr_t        ptr;         // pointer view
  int          fail_count;  // mismatches
  int          num_checks;  // comparisons
  mux_t        mlist [4] = '{MUX_8, MUX_16, MUX_24, MUX_32};
  order_t      olist [3] = '{ORD_CHAR, ORD_HALF, ORD_FULL};
  logic [1:0]  dots [4] = '{2'b00, 2'b01, 2'b11, 2'b10};  // columns 9,8 per status
  logic [5:0]  x;           // pointer model column
  logic [1:0]  b;           // pointer model bank
  // pin level: whoever has the drive wins
  assign clk_pin = clk_oe ? clk_out : ext_clk;
  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  lcd_matrix_row_column_controller #(.OSC_DIV_CYC(DIV)) lcd_matrix_row_column_controller_inst (
    .clock(clock), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
    .osc_resistor_input(strap), .cascade_clk_in(clk_pin), .cascade_clk_out(clk_out),
    .cascade_clk_oe(clk_oe), .frame_sync_n(sync_n), .drv_is_row(is_row),
    .drv_on(drv_on), .cfg(cfg), .ptr(ptr));
  lcd_ext_clock_src #(.HALF_NS(EXT * 20)) lcd_ext_clock_src_inst (
    .run(strap), .ext_clk(ext_clk));
  // compare of port values
  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one-cycle write, settled view on return
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req <= '0;
    #1;
  endtask : reg_wr
  task automatic xfer(input logic [7:0] d);
    reg_wr(`ADDR_XFER, d);
  endtask : xfer
  // read, data looked at in the single cycle it stands
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req <= '0;
    #1;
    chk("rdata", {32'h0, exp}, {32'h0, rdata});
  endtask : rd_chk
  // pointer set-up; the X load closes the commands
  task automatic load_ptr(input logic [3:0] s, input order_t o, input logic [1:0] bk,
                          input logic [5:0] c);
    reg_wr(`ADDR_START, 8'h00);
    xfer({4'hE, s});
    xfer({4'hF, o, bk});
    xfer({2'b00, c});
  endtask : load_ptr
  task automatic set_mode(input logic t, input status_t st, input mux_t m);
    reg_wr(`ADDR_START, 8'h00);
    xfer({3'b010, t, st, m});
  endtask : set_mode
  // bounded wait for a frame start
  task automatic wait_fall(output int n);
    logic prev;
    for (n = 1; n <= 4000; n++) begin
      prev = sync_n;
      @(posedge clock);
      #1;
      if (prev && !sync_n) break;
    end
    if (n > 4000) chk("sync timeout", 40'h0, 40'h1);
  endtask : wait_fall
  // two frame starts let a new setting take hold
  task automatic settle;
    int n;
    wait_fall(n);
    wait_fall(n);
  endtask : settle
  task automatic frame_chk(input int width, input int period);
    int n, w;
    settle();
    chk("clk pin", 40'h1, {39'h0, clk_pin});
    for (w = 0; w < 4000 && !sync_n; w++) begin
      @(posedge clock);
      #1;
    end
    wait_fall(n);
    chk("sync width", 40'(width), 40'(w));
    chk("frame period", 40'(period), 40'(w + n));
  endtask : frame_chk
  // row select, sampled mid cascade period
  task automatic scan_chk(input mux_t m);
    int p, k, r;
    logic [39:0] e;
    p = DIV * ((m == MUX_24) ? 8 : 6);
    e = (m == MUX_8) ? 40'h0001010101 : (m == MUX_16) ? 40'h0000010001 : 40'h1;
    settle();
    repeat (p / 2) @(posedge clock);
    for (k = 0; k < ((m == MUX_24) ? 24 : 32); k++) begin
      #1;
      r = (m == MUX_8) ? k / 4 : (m == MUX_16) ? k / 2 : k;
      chk("row select", e << r, drv_on);
      repeat (p) @(posedge clock);
    end
    chk("row mask", 40'h00FFFFFFFF, is_row);
  endtask : scan_chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  // hang guard, well past the expected run length
  initial begin
    repeat (70000) @(posedge clock);
    fail_count++;
    end_of_test();
  end
  initial begin
    fail_count = 0;
    num_checks = 0;
    resetn = 1'b0;
    strap = 1'b0;
    bus_req = '0;
    repeat (6) @(posedge clock);
    resetn <= 1'b0;
    @(posedge clock);
    resetn <= 1'b1;
    repeat (25000) @(posedge clock);
    chk("cfg", 40'h0, {33'h0, cfg});
    chk("ptr", 40'h0, {26'h0, ptr});
    rd_chk(`ADDR_CFG, 8'h00);
    rd_chk(`ADDR_PTR, 8'h00);
    rd_chk(4'hF, 8'h00);
    // row mode: data neither stored nor stepped
    load_ptr(4'h0, ORD_CHAR, 2'h0, 6'h03);
    xfer(8'h5A);
    chk("ptr x", 40'h3, {34'h0, ptr.x});
    rd_chk(`ADDR_XFER, 8'h00);
    foreach (mlist[i]) begin
      set_mode(1'b0, ST_NORMAL, mlist[i]);
      scan_chk(mlist[i]);
      frame_chk(DIV * ((mlist[i] == MUX_24) ? 8 : 6), DIV * 192);
    end
    // mixed mode: rows follow the rate, the rest are columns
    for (int i = 0; i < 3; i++) begin
      set_mode(1'b1, ST_NORMAL, mlist[i]);
      settle();
      chk("row mask", (40'h1 << (8 * (i + 1))) - 40'h1, is_row);
    end
    load_ptr(4'h0, ORD_CHAR, 2'h1, 6'h05);
    xfer(8'h3C);
    xfer(8'hA5);
    chk("ptr x", 40'h7, {34'h0, ptr.x});
    load_ptr(4'h0, ORD_CHAR, 2'h1, 6'h05);
    rd_chk(`ADDR_XFER, 8'h3C);
    rd_chk(`ADDR_XFER, 8'hA5);
    foreach (olist[i]) begin
      load_ptr(4'h0, olist[i], 2'h0, 6'h0A);
      x = 6'h0A;
      b = 2'h0;
      for (int j = 0; j < 5; j++) begin
        xfer(8'(j));
        case (olist[i])
          ORD_HALF: begin x = x + 6'(b[0]); b = b ^ 2'h1; end
          ORD_FULL: begin x = x + 6'(b == 2'h3); b = b + 2'h1; end
          default:  x = x + 6'h1;
        endcase
        chk("ptr step", {32'h0, x, b}, {32'h0, ptr.x, ptr.bank});
      end
    end
    load_ptr(4'hF, ORD_CHAR, 2'h0, 6'h27);
    xfer(8'h00);
    chk("ptr wrap", 40'h0, {30'h0, ptr.sub, ptr.x});
    // another subaddress: pointer steps but memory keeps its byte
    load_ptr(4'h0, ORD_CHAR, 2'h0, 6'h14);
    xfer(8'h11);
    load_ptr(4'h1, ORD_CHAR, 2'h0, 6'h14);
    xfer(8'h77);
    chk("ptr x", 40'h15, {34'h0, ptr.x});
    load_ptr(4'h0, ORD_CHAR, 2'h0, 6'h14);
    rd_chk(`ADDR_XFER, 8'h11);
    // pixels on columns 8 and 9, row 0 of banks 0 and 1
    load_ptr(4'h0, ORD_CHAR, 2'h0, 6'h08);
    xfer(8'h01);
    xfer(8'h00);
    load_ptr(4'h0, ORD_CHAR, 2'h1, 6'h08);
    xfer(8'h00);
    xfer(8'h01);
    for (int s = 0; s < 4; s++) begin
      set_mode(1'b1, status_t'(s), MUX_8);
      settle();
      chk("dots", {38'h0, dots[s]}, {38'h0, drv_on[9:8]});
    end
    set_mode(1'b1, ST_NORMAL, MUX_8);
    reg_wr(`ADDR_START, 8'h00);
    xfer({6'b011111, 2'h1});
    chk("top bank", 40'h1, {38'h0, cfg.top_bank});
    settle();
    chk("dots", 40'h2, {38'h0, drv_on[9:8]});
    // external clock: pin released, frame follows the partner clock
    set_mode(1'b0, ST_NORMAL, MUX_32);
    strap <= 1'b1;
    frame_chk(EXT, 32 * EXT);
    chk("clk oe", 40'h0, {39'h0, clk_oe});
    end_of_test();
  end
endmodule : lcd_matrix_row_column_controller_test
